// ---- iommu_dac_pkg.sv ----
package iommu_dac_pkg;

  // ==========================================================================
  // bus and register map
  localparam int DATA_W = 32;
  localparam int REG_ADDR_W = 12;
  localparam logic [REG_ADDR_W-1:0] OFF_CTRL1 = 12'h0b4;
  localparam logic [REG_ADDR_W-1:0] OFF_REFUSE_CNT = 12'h0c0;
  localparam logic [REG_ADDR_W-1:0] OFF_REFUSE_STAT = 12'h0c4;

  // ==========================================================================
  // permission control word
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
  // bits 15:14 and 31:25 hold nothing here and read as zero
  localparam logic [DATA_W-1:0] CTRL_RW_MASK = 32'h01ff_3fff;
  localparam logic [2:0] DOM2 = 3'h2;
  localparam logic [2:0] DOM3 = 3'h3;
  localparam logic [4:0] DOM2_BASE = 5'h00;
  localparam logic [4:0] DOM3_BASE = 5'h10;
  // masters below this index are checked in domain 2
  localparam logic [2:0] DOM2_LIVE_MASTERS = 3'h6;
  // last {master, write} slot checked in domain 3 (master 4 read)
  localparam logic [3:0] DOM3_LAST_SLOT = 4'h8;

  // ==========================================================================
  // refusal status word
  localparam int STAT_RD_BIT = 0;
  localparam int STAT_WR_BIT = 1;
  localparam int STAT_MST_LSB = 4;
  localparam int STAT_DOM_LSB = 8;

endpackage

// ---- dac_check_if.sv ----
`timescale 1ns/1ps
interface dac_check_if;
  logic [iommu_dac_pkg::DATA_W-1:0] ctrl;
  logic [2:0] domain;
  logic [2:0] master;
  logic write;
  logic checked;
  logic block;
  modport lookup (input ctrl, input domain, input master, input write,
                  output checked, output block);
  modport owner (output ctrl, output domain, output master, output write,
                 input checked, input block);
endinterface

// ---- dac_perm_lookup.sv ----
`timescale 1ns/1ps
module dac_perm_lookup (
  dac_check_if.lookup chk
);

  logic [3:0] slot;
  logic [4:0] idx;
  logic in_d2;
  logic in_d3;

  // ==========================================================================
  // bit select: two bits per master, read at even, write at odd position
  always_comb begin
    slot = {chk.master, chk.write};
    in_d2 = (chk.domain == iommu_dac_pkg::DOM2) &&
            (chk.master < iommu_dac_pkg::DOM2_LIVE_MASTERS);
    in_d3 = (chk.domain == iommu_dac_pkg::DOM3) &&
            (slot <= iommu_dac_pkg::DOM3_LAST_SLOT);
    if (in_d3) begin
      idx = iommu_dac_pkg::DOM3_BASE + {1'b0, slot};
    end else begin
      idx = iommu_dac_pkg::DOM2_BASE + {1'b0, slot};
    end
    chk.checked = in_d2 | in_d3;
    // a set bit refuses, a clear bit lets the access through
    chk.block = chk.checked & chk.ctrl[idx];
  end

endmodule

// ---- iommu_domain_access_check.sv ----
`timescale 1ns/1ps
// ============================================================================
// Contract
// - domain 3 master 4 reads refused while bit 24 set, reset zero.
// - domain 3 master 3 writes refused while bit 23 set.
// - domain 3 master 3 reads refused while bit 22 set.
// - domain 3 master 2 writes refused while bit 21 set.
// - domain 3 master 2 reads refused while bit 20 set.
// - domain 3 master 1 writes refused while bit 19 set.
// - domain 3 master 1 reads refused while bit 18 set.
// - domain 3 master 0 writes follow bit 17, reads bit 16.
// - domain 2 master 6 bits 13 and 12 store only, never refuse.
// - domain 2 master 5 writes follow bit 11, reads bit 10.
// - domain 2 master 4 writes follow bit 9, reads bit 8.
// - domain 2 master 3 writes follow bit 7, reads bit 6.
// - domain 2 master 2 writes follow bit 5, reads bit 4.
// - domain 2 master 1 writes follow bit 3, reads bit 2.
// - domain 2 master 0 writes refused while bit 1 set.
// - all permission bits reset to zero, everything allowed.
// - domain 2 master 0 reads refused while bit 0 set, reset zero.
module iommu_domain_access_check #(
  parameter int ADDR_W = 32,
  parameter int CNT_W = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [iommu_dac_pkg::REG_ADDR_W-1:0] i_paddr,
  input wire logic [iommu_dac_pkg::DATA_W-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [iommu_dac_pkg::DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic [2:0] i_req_domain,
  input wire logic [2:0] i_req_master,
  input wire logic i_req_write,
  input wire logic [ADDR_W-1:0] i_req_addr,
  output logic o_rsp_valid,
  input wire logic i_rsp_ready,
  output logic o_rsp_allow,
  output logic [2:0] o_rsp_domain,
  output logic [2:0] o_rsp_master,
  output logic o_rsp_write,
  output logic [ADDR_W-1:0] o_rsp_addr
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [iommu_dac_pkg::DATA_W-1:0] ctrl;
    logic [CNT_W-1:0] refuse_cnt;
    logic rd_refused;
    logic wr_refused;
    logic [2:0] last_dom;
    logic [2:0] last_mst;
    logic rsp_valid;
    logic rsp_allow;
    logic [2:0] rsp_dom;
    logic [2:0] rsp_mst;
    logic rsp_wr;
    logic [ADDR_W-1:0] rsp_addr;
    logic [iommu_dac_pkg::DATA_W-1:0] prdata;
    logic pslverr;
  } state_t;

  state_t q;
  state_t d;

  dac_check_if chk();

  logic take;
  logic apb_setup;
  logic apb_wr;
  logic sel_ctrl;
  logic sel_cnt;
  logic sel_stat;
  logic [iommu_dac_pkg::DATA_W-1:0] lane_mask;
  logic [iommu_dac_pkg::DATA_W-1:0] stat_word;
  logic [iommu_dac_pkg::DATA_W-1:0] rd_word;

  // ==========================================================================
  // permission lookup
  assign chk.ctrl = q.ctrl;
  assign chk.domain = i_req_domain;
  assign chk.master = i_req_master;
  assign chk.write = i_req_write;

  dac_perm_lookup u_lookup (
    .chk(chk)
  );

  // ==========================================================================
  // request path: one register stage, stalls only on the downstream side
  assign o_req_ready = ~q.rsp_valid | i_rsp_ready;
  assign take = i_req_valid & o_req_ready;

  // ==========================================================================
  // apb decode; zero wait states, read data captured in the setup cycle
  assign apb_setup = i_psel & ~i_penable;
  assign apb_wr = i_psel & i_penable & i_pwrite;
  assign sel_ctrl = (i_paddr == iommu_dac_pkg::OFF_CTRL1);
  assign sel_cnt = (i_paddr == iommu_dac_pkg::OFF_REFUSE_CNT);
  assign sel_stat = (i_paddr == iommu_dac_pkg::OFF_REFUSE_STAT);
  assign lane_mask = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}}, {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};

  always_comb begin
    stat_word = '0;
    stat_word[iommu_dac_pkg::STAT_RD_BIT] = q.rd_refused;
    stat_word[iommu_dac_pkg::STAT_WR_BIT] = q.wr_refused;
    stat_word[iommu_dac_pkg::STAT_MST_LSB +: 3] = q.last_mst;
    stat_word[iommu_dac_pkg::STAT_DOM_LSB +: 3] = q.last_dom;
    rd_word = '0;
    if (sel_ctrl) begin
      rd_word = q.ctrl & iommu_dac_pkg::CTRL_RW_MASK;
    end else if (sel_cnt) begin
      rd_word[CNT_W-1:0] = q.refuse_cnt;
    end else if (sel_stat) begin
      rd_word = stat_word;
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    d = q;

    if (apb_setup) begin
      d.prdata = rd_word;
      d.pslverr = ~(sel_ctrl | sel_cnt | sel_stat);
    end

    // unused bits never store, so they cannot leak back on a read
    if (apb_wr && sel_ctrl) begin
      d.ctrl = ((q.ctrl & ~lane_mask) | (i_pwdata & lane_mask)) &
               iommu_dac_pkg::CTRL_RW_MASK;
    end

    // software clears first so that a refusal in the same cycle survives
    if (apb_wr && sel_cnt && i_pstrb[0]) begin
      d.refuse_cnt = '0;
    end
    if (apb_wr && sel_stat && i_pstrb[0]) begin
      if (i_pwdata[iommu_dac_pkg::STAT_RD_BIT]) begin
        d.rd_refused = 1'b0;
      end
      if (i_pwdata[iommu_dac_pkg::STAT_WR_BIT]) begin
        d.wr_refused = 1'b0;
      end
    end

    if (take) begin
      d.rsp_valid = 1'b1;
      d.rsp_allow = ~chk.block;
      d.rsp_dom = i_req_domain;
      d.rsp_mst = i_req_master;
      d.rsp_wr = i_req_write;
      d.rsp_addr = i_req_addr;
      if (chk.block) begin
        // the counter saturates rather than wrapping to a false zero
        if (d.refuse_cnt != {CNT_W{1'b1}}) begin
          d.refuse_cnt = d.refuse_cnt + 1'b1;
        end
        if (i_req_write) begin
          d.wr_refused = 1'b1;
        end else begin
          d.rd_refused = 1'b1;
        end
        d.last_dom = i_req_domain;
        d.last_mst = i_req_master;
      end
    end else if (i_rsp_ready) begin
      d.rsp_valid = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      q <= '0;
      q.ctrl <= iommu_dac_pkg::CTRL_RESET;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // outputs
  assign o_prdata = q.prdata;
  assign o_pready = 1'b1;
  assign o_pslverr = q.pslverr;
  assign o_rsp_valid = q.rsp_valid;
  assign o_rsp_allow = q.rsp_allow;
  assign o_rsp_domain = q.rsp_dom;
  assign o_rsp_master = q.rsp_mst;
  assign o_rsp_write = q.rsp_wr;
  assign o_rsp_addr = q.rsp_addr;

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  property p_gate(logic [2:0] dm, logic [2:0] ms, logic wr, int bn);
    take && i_req_domain == dm && i_req_master == ms && i_req_write == wr
    |=> o_rsp_valid && (o_rsp_allow == !$past(q.ctrl[bn]));
  endproperty

  sequence s_ctrl_write;
    apb_setup && i_pwrite && sel_ctrl ##1 apb_wr && sel_ctrl;
  endsequence

  sequence s_ctrl_read;
    apb_setup && !i_pwrite && sel_ctrl;
  endsequence

  chk_d3m4_read: assert property (p_gate(3'h3, 3'h4, 1'b0, 24))
    else $error("domain 3 master 4 read decision wrong");
  chk_d3m3_write: assert property (p_gate(3'h3, 3'h3, 1'b1, 23))
    else $error("domain 3 master 3 write decision wrong");
  chk_d3m3_read: assert property (p_gate(3'h3, 3'h3, 1'b0, 22))
    else $error("domain 3 master 3 read decision wrong");
  chk_d3m2_write: assert property (p_gate(3'h3, 3'h2, 1'b1, 21))
    else $error("domain 3 master 2 write decision wrong");
  chk_d3m2_read: assert property (p_gate(3'h3, 3'h2, 1'b0, 20))
    else $error("domain 3 master 2 read decision wrong");
  chk_d3m1_write: assert property (p_gate(3'h3, 3'h1, 1'b1, 19))
    else $error("domain 3 master 1 write decision wrong");
  chk_d3m1_read: assert property (p_gate(3'h3, 3'h1, 1'b0, 18))
    else $error("domain 3 master 1 read decision wrong");
  chk_d3m0_write: assert property (p_gate(3'h3, 3'h0, 1'b1, 17))
    else $error("domain 3 master 0 write decision wrong");
  chk_d3m0_read: assert property (p_gate(3'h3, 3'h0, 1'b0, 16))
    else $error("domain 3 master 0 read decision wrong");

  chk_d2m6_allowed: assert property (
    take && i_req_domain == 3'h2 && i_req_master == 3'h6 |=> o_rsp_valid && o_rsp_allow)
    else $error("domain 2 master 6 was refused");

  chk_d2m5_write: assert property (p_gate(3'h2, 3'h5, 1'b1, 11))
    else $error("domain 2 master 5 write decision wrong");
  chk_d2m4_read: assert property (p_gate(3'h2, 3'h4, 1'b0, 8))
    else $error("domain 2 master 4 read decision wrong");
  chk_d2m3_write: assert property (p_gate(3'h2, 3'h3, 1'b1, 7))
    else $error("domain 2 master 3 write decision wrong");
  chk_d2m2_read: assert property (p_gate(3'h2, 3'h2, 1'b0, 4))
    else $error("domain 2 master 2 read decision wrong");
  chk_d2m1_write: assert property (p_gate(3'h2, 3'h1, 1'b1, 3))
    else $error("domain 2 master 1 write decision wrong");
  chk_d2m0_write: assert property (p_gate(3'h2, 3'h0, 1'b1, 1))
    else $error("domain 2 master 0 write decision wrong");
  chk_d2m0_read: assert property (p_gate(3'h2, 3'h0, 1'b0, 0))
    else $error("domain 2 master 0 read decision wrong");

  chk_reset_clears_ctrl: assert property (
    @(posedge i_clk_sys) disable iff (1'b0)
    i_rst |=> q.ctrl == '0 && !o_rsp_valid)
    else $error("permission bits not zero after reset");

  chk_unused_no_store: assert property (s_ctrl_write |=> q.ctrl[15:14] == 2'h0)
    else $error("unused control bits stored a write");
  chk_unused_read_zero: assert property (s_ctrl_read |=> o_prdata[15:14] == 2'h0)
    else $error("unused control bits read nonzero");

  chk_rsp_from_take: assert property (
    o_rsp_valid && !$past(o_rsp_valid) |-> $past(take))
    else $error("response without an accepted request");
  chk_refusal_counted: assert property (
    take && chk.block && q.refuse_cnt != {CNT_W{1'b1}} |=> q.refuse_cnt != '0 && q.wr_refused | q.rd_refused)
    else $error("refused access not recorded");

  chk_d2m5_read: assert property (p_gate(3'h2, 3'h5, 1'b0, 10))
    else $error("domain 2 master 5 read decision wrong");
  chk_d2m4_write: assert property (p_gate(3'h2, 3'h4, 1'b1, 9))
    else $error("domain 2 master 4 write decision wrong");
  chk_d2m3_read: assert property (p_gate(3'h2, 3'h3, 1'b0, 6))
    else $error("domain 2 master 3 read decision wrong");
  chk_d2m2_write: assert property (p_gate(3'h2, 3'h2, 1'b1, 5))
    else $error("domain 2 master 2 write decision wrong");
  chk_d2m1_read: assert property (p_gate(3'h2, 3'h1, 1'b0, 2))
    else $error("domain 2 master 1 read decision wrong");

  // ==========================================================================
  // accesses outside the checked slots always pass
  chk_d3m4_write_free: assert property (
    take && i_req_domain == 3'h3 && i_req_master == 3'h4 && i_req_write
    |=> o_rsp_valid && o_rsp_allow)
    else $error("domain 3 master 4 write was refused");
  chk_other_dom_free: assert property (
    take && i_req_domain != 3'h2 && i_req_domain != 3'h3 |=> o_rsp_valid && o_rsp_allow)
    else $error("unchecked domain was refused");

  // ==========================================================================
  // forwarding: a decision carries its own request and waits for the sink
  sequence s_rsp_stalled;
    o_rsp_valid && !i_rsp_ready;
  endsequence

  chk_rsp_fields: assert property (
    take |=> o_rsp_domain == $past(i_req_domain) && o_rsp_master == $past(i_req_master) &&
    o_rsp_write == $past(i_req_write) && o_rsp_addr == $past(i_req_addr))
    else $error("forwarded fields differ from the request");
  chk_rsp_hold: assert property (
    s_rsp_stalled |=> o_rsp_valid && $stable(o_rsp_allow) && $stable(o_rsp_addr))
    else $error("stalled decision changed");
  chk_rsp_drop: assert property (
    o_rsp_valid && i_rsp_ready && !take |=> !o_rsp_valid)
    else $error("accepted decision not withdrawn");

  // ==========================================================================
  // refusal record: a refusal in the same cycle wins over a software clear
  sequence s_refused;
    take && chk.block;
  endsequence

  chk_refusal_source: assert property (
    s_refused |=> q.last_dom == $past(i_req_domain) && q.last_mst == $past(i_req_master))
    else $error("last refusal source not recorded");
  chk_allowed_uncounted: assert property (
    take && !chk.block && !(apb_wr && sel_cnt && i_pstrb[0]) |=> $stable(q.refuse_cnt))
    else $error("allowed access changed the refusal count");
  chk_count_clear: assert property (
    apb_wr && sel_cnt && i_pstrb[0] && !(take && chk.block) |=> q.refuse_cnt == '0)
    else $error("refusal count not cleared");
  chk_status_clear: assert property (
    apb_wr && sel_stat && i_pstrb[0] && i_pwdata[iommu_dac_pkg::STAT_RD_BIT] &&
    !(take && chk.block && !i_req_write) |=> !q.rd_refused)
    else $error("read refusal flag not cleared");

  // ==========================================================================
  // register port
  sequence s_unmapped;
    apb_setup && !(sel_ctrl || sel_cnt || sel_stat);
  endsequence

  sequence s_ctrl_full_write;
    apb_setup && i_pwrite && sel_ctrl && i_pstrb == 4'hf ##1 apb_wr && sel_ctrl;
  endsequence

  chk_unmapped_error: assert property (s_unmapped |=> o_pslverr && o_prdata == '0)
    else $error("unmapped access not refused");
  chk_ctrl_stores: assert property (
    s_ctrl_full_write |=> q.ctrl == ($past(i_pwdata) & iommu_dac_pkg::CTRL_RW_MASK))
    else $error("control word did not store the write");
  chk_ctrl_readback: assert property (s_ctrl_read |=> o_prdata == $past(q.ctrl))
    else $error("control word read back wrong");
  chk_reset_outputs: assert property (
    @(posedge i_clk_sys) disable iff (1'b0)
    i_rst |=> !o_pslverr && o_prdata == '0 && o_req_ready)
    else $error("register port not idle after reset");

endmodule

// ---- dac_master_model.sv ----
`timescale 1ns/1ps
module dac_master_model (
  input wire logic i_clk_sys,
  input wire logic i_req_ready,
  input wire logic i_rsp_valid,
  input wire logic i_rsp_allow,
  input wire logic [2:0] i_rsp_domain,
  input wire logic [2:0] i_rsp_master,
  input wire logic i_rsp_write,
  input wire logic [31:0] i_rsp_addr,
  output logic o_req_valid,
  output logic [2:0] o_req_domain,
  output logic [2:0] o_req_master,
  output logic o_req_write,
  output logic [31:0] o_req_addr,
  output logic o_rsp_ready
);
  initial begin
    o_req_valid = 1'b0;
    o_req_domain = 3'h0;
    o_req_master = 3'h0;
    o_req_write = 1'b0;
    o_req_addr = 32'h0;
    o_rsp_ready = 1'b1;
  end
  // ==========================================================================
  // one access; a stall holds the answer back, which must then stay put
  task automatic access(input logic [2:0] d, input logic [2:0] m, input logic w,
      input int stall, output logic allow, output logic ok);
    logic [31:0] a;
    int n;
    a = $urandom;
    n = 0;
    @(posedge i_clk_sys);
    o_req_valid <= 1'b1;
    o_req_domain <= d;
    o_req_master <= m;
    o_req_write <= w;
    o_req_addr <= a;
    o_rsp_ready <= (stall == 0);
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (i_req_ready !== 1'b1 && n < 50);
    // released lines carry the inverse so a stale value never passes as live
    o_req_valid <= 1'b0;
    o_req_domain <= ~d;
    o_req_master <= ~m;
    o_req_write <= ~w;
    o_req_addr <= ~a;
    repeat (stall) @(posedge i_clk_sys);
    o_rsp_ready <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (i_rsp_valid !== 1'b1 && n < 100);
    allow = i_rsp_allow;
    ok = (n < 100) && i_rsp_domain === d && i_rsp_master === m;
    ok = ok && i_rsp_write === w && i_rsp_addr === a;
  endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  localparam logic [11:0] CTRL = iommu_dac_pkg::OFF_CTRL1;
  localparam logic [11:0] CNT = iommu_dac_pkg::OFF_REFUSE_CNT;
  localparam logic [11:0] STAT = iommu_dac_pkg::OFF_REFUSE_STAT;
  logic [31:0] cnt_model, stat_model;
  logic i_clk_sys, i_rst, i_psel, i_penable, i_pwrite;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, i_req_addr, o_rsp_addr, ctrl_model;
  logic [3:0] i_pstrb;
  logic o_pready, o_pslverr, i_req_valid, o_req_ready, i_req_write, o_rsp_valid;
  logic i_rsp_ready, o_rsp_allow, o_rsp_write;
  logic [2:0] i_req_domain, i_req_master, o_rsp_domain, o_rsp_master;
  int err_count, checks_done;

  iommu_domain_access_check iommu_domain_access_check_i (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .i_req_domain(i_req_domain),
    .i_req_master(i_req_master), .i_req_write(i_req_write), .i_req_addr(i_req_addr),
    .o_rsp_valid(o_rsp_valid), .i_rsp_ready(i_rsp_ready), .o_rsp_allow(o_rsp_allow),
    .o_rsp_domain(o_rsp_domain), .o_rsp_master(o_rsp_master), .o_rsp_write(o_rsp_write),
    .o_rsp_addr(o_rsp_addr));
  dac_master_model dac_master_model_i (
    .i_clk_sys(i_clk_sys), .i_req_ready(o_req_ready), .i_rsp_valid(o_rsp_valid),
    .i_rsp_allow(o_rsp_allow), .i_rsp_domain(o_rsp_domain), .i_rsp_master(o_rsp_master),
    .i_rsp_write(o_rsp_write), .i_rsp_addr(o_rsp_addr), .o_req_valid(i_req_valid),
    .o_req_domain(i_req_domain), .o_req_master(i_req_master), .o_req_write(i_req_write),
    .o_req_addr(i_req_addr), .o_rsp_ready(i_rsp_ready));

  // ==========================================================================
  // shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic reg_op(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
    logic [31:0] m;
    logic hit;
    int n;
    hit = a inside {CTRL, CNT, STAT};
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    n = 0;
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    i_pstrb <= s;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    check(o_pready, 1'b1, "pready");
    check(o_pslverr, !hit, "pslverr");
    if (!wr && a == CTRL) check(o_prdata, ctrl_model, "ctrl read");
    if (!wr && a == CNT) check(o_prdata, cnt_model, "refusal count");
    if (!wr && a == STAT) check(o_prdata, stat_model, "refusal status");
    if (!wr && !hit) check(o_prdata, 32'h0, "unmapped read");
    if (wr && a == CTRL) ctrl_model = ((ctrl_model & ~m) | (d & m)) & 32'h01ff_3fff;
    if (wr && a == CNT && s[0]) cnt_model = 32'h0;
    if (wr && a == STAT && s[0]) stat_model[1:0] = stat_model[1:0] & ~d[1:0];
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic acc(input int d, input int m, input int w);
    logic al, ok, e;
    e = 1'b1;
    if (d == 2 && m < 6) e = !ctrl_model[2*m+w];
    if (d == 3 && 2*m+w <= 8) e = !ctrl_model[16+2*m+w];
    dac_master_model_i.access(d[2:0], m[2:0], w[0], $urandom_range(2), al, ok);
    if (!e) begin
      cnt_model = cnt_model + 32'h1;
      stat_model[w] = 1'b1;
      stat_model[6:4] = m[2:0];
      stat_model[10:8] = d[2:0];
    end
    if (d == 3) check(al, e, "allow");
    else check(al, e, "allow");
    check(ok, 1'b1, "fields");
  endtask
  task automatic do_reset();
    i_rst <= 1'b1;
    repeat (5) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    ctrl_model = 32'h0;
    cnt_model = 32'h0;
    stat_model = 32'h0;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // clock, watchdog and tests
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    err_count++;
    final_report();
  end
  initial begin
    {i_psel, i_penable, i_pwrite, i_rst} = 4'h1;
    i_paddr = 12'h0;
    i_pwdata = 32'h0;
    i_pstrb = 4'h0;
    err_count = 0;
    checks_done = 0;
    ctrl_model = 32'h0;
    void'($urandom(32'hbf2a));
    do_reset();
    reg_op(1'b0, CTRL, 32'h0, 4'h0);
    for (int b = 0; b < 25; b++) begin
      reg_op(1'b1, CTRL, 32'h1 << b, 4'hf);
      reg_op(1'b0, CTRL, 32'h0, 4'h0);
      for (int k = 0; k < 128; k++) acc(k / 16, (k / 2) % 8, k % 2);
    end
    $display("test walking bit done");
    for (int i = 0; i < 20; i++) begin
      reg_op(1'b1, CTRL, $urandom, 4'($urandom_range(15)));
      reg_op(1'b0, CTRL, 32'h0, 4'h0);
      repeat (16) acc($urandom_range(7), $urandom_range(7), $urandom_range(1));
    end
    $display("test random masks done");
    reg_op(1'b0, CNT, 32'h0, 4'h0);
    reg_op(1'b0, STAT, 32'h0, 4'h0);
    reg_op(1'b1, CNT, 32'h0, 4'h2);
    reg_op(1'b0, CNT, 32'h0, 4'h0);
    reg_op(1'b1, STAT, 32'h3, 4'h1);
    reg_op(1'b1, CNT, 32'h0, 4'h1);
    reg_op(1'b0, CNT, 32'h0, 4'h0);
    reg_op(1'b0, STAT, 32'h0, 4'h0);
    $display("test refusal record done");
    reg_op(1'b1, 12'h0b8, 32'hffff_ffff, 4'hf);
    reg_op(1'b0, 12'h0b8, 32'h0, 4'h0);
    reg_op(1'b0, CTRL, 32'h0, 4'h0);
    $display("test unmapped done");
    reg_op(1'b1, CTRL, 32'hffff_ffff, 4'hf);
    do_reset();
    reg_op(1'b0, CTRL, 32'h0, 4'h0);
    reg_op(1'b0, CNT, 32'h0, 4'h0);
    acc(3, 4, 0);
    acc(2, 0, 0);
    $display("test mid-run reset done");
    final_report();
  end
endmodule
